// *** dv/rxpo_panel.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// panel model latching output pixels
module rxpo_panel (
    // panel pins, clock pulled low when released
    input wire logic        invert,
    input wire logic        oe_b,
    input wire logic        pclk,
    input wire logic [35:0] pix,
    input wire logic        de
);
    logic [35:0] lat_q[$];
    logic        ck;

    // weak pull-down while the receiver lets go
    assign ck = oe_b ? 1'b0 : pclk;

    // latch on selected edge
    // settle first, a zero-time gating glitch is no edge
    always @(posedge ck or negedge ck) begin
        #1;
        if (ck == invert && !oe_b && de === 1'b1)
            lat_q.push_back(pix);
    end
endmodule
`default_nettype wire

// *** dv/rxpo_top_test.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// self-checking bench for pixel output block
module rxpo_top_test;
    import rxpo_pkg::*;
    localparam int DL = 200;
    localparam int LL = 300;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        pps = 1'b0, inv = 1'b0, fmt = 1'b0;
    logic        dss = 1'b1, pdn = 1'b1, odn = 1'b1;
    logic        link_clk = 1'b0, link_de = 1'b0;
    logic [23:0] link_pixel = 24'h00_0000;
    logic [2:0]  link_ctl = 3'h0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, rd_d;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    wire  logic [31:0] reg_rdata;
    wire  logic [35:0] pix_bus;
    wire  logic  irq, opc, de_out, oe_b, sync_det, dsf;
    wire  logic  hs_o, vs_o, c1, c2, c3;
    int          error_cnt = 0, total_checks = 0;
    int          nleft = 0, k = 0, act = 6, hi_cnt = 0;
    logic [23:0] exp_q[$];

    rxpo_top #(.DE_LOSS(DL), .LINK_LOSS(LL), .SYNC_ON(SYNC_ON_EDGES)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .pixels_per_clock_select(pps),
        .output_clock_invert(inv), .output_format_select(fmt),
        .drive_strength_select(dss), .power_down_n(pdn), .output_disable_n(odn),
        .link_clk(link_clk), .link_pixel(link_pixel), .link_de(link_de),
        .link_hsync(~link_de), .link_vsync(1'b0), .link_ctl(link_ctl),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .pixel_out_bus(pix_bus), .output_pixel_clock(opc),
        .data_enable_out(de_out), .hsync_out(hs_o), .vsync_out(vs_o),
        .general_control_2(c2), .general_control_3(c3), .out_oe_b(oe_b),
        .general_control_1(c1), .sync_detect(sync_det), .drive_strength_full(dsf));
    rxpo_panel panel (.invert(inv), .oe_b(oe_b), .pclk(opc), .pix(pix_bus),
        .de(de_out));

    // reference clock
    initial forever #5 ref_clk = ~ref_clk;

    // link source, 125 ns pixels, clock still when idle
    initial forever begin
        wait (nleft > 0);
        link_de = (k % 8) < act;
        link_pixel = {k[7:0], ~k[7:0], k[7:0] ^ 8'h5a};
        link_ctl = k[2:0];
        if (link_de)
            exp_q.push_back(link_pixel);
        k++;
        #62 link_clk = 1'b1;
        #63 link_clk = 1'b0;
        nleft--;
    end

    // clock seen high while enable low
    always @(negedge ref_clk) begin
        if (opc === 1'b1 && de_out === 1'b0)
            hi_cnt++;
    end

    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic lines(input int n, input int a);
        act = a;
        nleft = 8 * n;
        wait (nleft == 0);
        tick(20);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic [17:0] pk(input logic [23:0] p);
        return {p[23:18], p[15:10], p[7:2]};
    endfunction

    task automatic t_sync();
        lines(6, 6);
        chk(sync_det, 1'b1, "detect after activity");
        lines(1, 0);
        chk(sync_det, 1'b1, "detect held in short idle");
        lines(2, 0);
        chk(sync_det, 1'b0, "detect after enable idle");
        lines(6, 6);
        chk(sync_det, 1'b1, "detect before link stop");
        tick(LL * 250 / 200);
        chk(sync_det, 1'b0, "detect after link stop");
        $display("test sync done");
    endtask

    task automatic t_irq();
        rd(REG_IRQ_STATUS, rd_d);
        chk(rd_d[2:0], 3'h7, "rise, fall and rate events");
        wr(REG_IRQ_MASK, 32'h0000_0001);
        tick(2);
        chk(irq, 1'b1, "unmasked event");
        wr(REG_IRQ_STATUS, 32'h0000_0001);
        tick(2);
        chk(irq, 1'b0, "cleared event");
        rd(REG_IRQ_MASK, rd_d);
        chk(rd_d[2:0], 3'h1, "mask readback");
        rd(8'h0c, rd_d);
        chk(rd_d, 32'h0000_0000, "unmapped read");
        wr(REG_STATUS, 32'h0000_000f);
        rd(REG_STATUS, rd_d);
        chk(rd_d[3:0], 4'h0, "status read only");
        $display("test irq done");
    endtask

    task automatic t_pix(input logic d, input logic i, input logic f, input int a);
        int n;
        int b;
        logic [35:0] e;
        @(posedge ref_clk);
        pps <= d;
        inv <= i;
        fmt <= f;
        tick(10);
        exp_q.delete();
        panel.lat_q.delete();
        hi_cnt = 0;
        lines(2, a);
        n = d ? a / 2 : a;
        chk(panel.lat_q.size(), 2 * n, "latched count");
        for (int j = 0; j < 2 * n; j++) begin
            b = (j / n) * a + 2 * (j % n);
            e = d ? {pk(exp_q[b + 1]), pk(exp_q[b])} : {12'h000, exp_q[j]};
            chk(panel.lat_q[j], e, "latched pixel");
        end
        chk(hi_cnt == 0, f, "clock gating");
        chk(opc, f ? 1'b0 : i, "idle clock level");
        // last link pixel of a line is idle: controls all ones, hsync high
        chk({hs_o, vs_o, c3, c2, c1}, 5'h17, "controls after line");
        $display("test pixels done");
    endtask

    task automatic t_power();
        act = 6;
        nleft = 8 * 30;
        tick(400);
        @(posedge ref_clk);
        odn <= 1'b0;
        dss <= 1'b0;
        tick(10);
        chk(oe_b, 1'b1, "released on disable");
        chk(sync_det, 1'b1, "detect driven when disabled");
        chk(dsf, 1'b0, "reduced drive");
        panel.lat_q.delete();
        tick(100);
        chk(panel.lat_q.size(), 0, "no latching when released");
        @(posedge ref_clk);
        odn <= 1'b1;
        pdn <= 1'b0;
        dss <= 1'b1;
        tick(10);
        chk(oe_b, 1'b1, "released in power down");
        chk(sync_det, 1'b0, "detect cleared in power down");
        @(posedge ref_clk);
        pdn <= 1'b1;
        wait (nleft == 0);
        tick(10);
        chk(oe_b, 1'b0, "driven after power up");
        chk(sync_det, 1'b1, "detect back after power up");
        chk(dsf, 1'b1, "full drive");
        $display("test power done");
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        tick(5);
        rd(REG_IRQ_MASK, rd_d);
        chk(rd_d[2:0], IRQ_MASK_RST, "mask reset value");
        t_sync();
        t_irq();
        t_pix(1'b0, 1'b0, 1'b0, 6);
        t_pix(1'b0, 1'b1, 1'b1, 6);
        t_pix(1'b1, 1'b0, 1'b1, 5);
        t_pix(1'b1, 1'b1, 1'b0, 5);
        t_power();
        conclude();
    end

    // watchdog, about three times the expected run
    initial begin
        #200000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire

// *** inc/rxpo_pkg.sv ***
// ==========================================================
// pixel output and sync detect constants
`default_nettype none
package rxpo_pkg;
    // bus widths
    localparam int PIX_W    = 36;
    localparam int LINK_W   = 24;
    localparam int HALF_W   = 18;
    localparam int TMR_W    = 25;
    localparam int IRQ_W    = 3;

    // register offsets
    localparam logic [7:0] REG_STATUS     = 8'h00;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK   = 8'h08;

    // status fields
    localparam int STAT_SYNC     = 0;
    localparam int STAT_DUAL     = 1;
    localparam int STAT_PWR_DOWN = 2;
    localparam int STAT_OUT_OFF  = 3;

    // interrupt fields and reset values
    localparam int IRQ_SYNC_UP   = 0;
    localparam int IRQ_SYNC_DOWN = 1;
    localparam int IRQ_RATE      = 2;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // reference clock
    localparam int REF_PERIOD_PS = 10000;
    localparam int REF_KHZ       = 100000;

    // output clock high time, fixed by this block
    localparam int CLK_HIGH_PS  = 40000;
    localparam int CLK_HIGH_CYC = CLK_HIGH_PS / REF_PERIOD_PS;

    // output clock period limits, single and dual pixel mode
    localparam int SINGLE_MIN_PS  = 11600;
    localparam int SINGLE_MAX_PS  = 50000;
    localparam int DUAL_MIN_PS    = 23300;
    localparam int DUAL_MAX_PS    = 100000;
    localparam int SINGLE_MIN_CYC = (SINGLE_MIN_PS + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    localparam int SINGLE_MAX_CYC = SINGLE_MAX_PS / REF_PERIOD_PS;
    localparam int DUAL_MIN_CYC   = (DUAL_MIN_PS + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
    localparam int DUAL_MAX_CYC   = DUAL_MAX_PS / REF_PERIOD_PS;

    // sync detect timing
    localparam int DE_LOSS_MS      = 160;
    localparam int LINK_LOSS_MS    = 200;
    localparam int LINK_LOSS_MAXMS = 250;
    localparam int DE_LOSS_CYC     = DE_LOSS_MS * REF_KHZ;
    localparam int LINK_LOSS_CYC   = LINK_LOSS_MS * REF_KHZ;
    localparam int SYNC_MAX_EDGES  = 40;
    localparam int SYNC_ON_EDGES   = 3;
endpackage
`default_nettype wire

// *** rtl/rxpo_top.sv ***
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module rxpo_top
    import rxpo_pkg::*;
#(
    parameter int unsigned DE_LOSS   = rxpo_pkg::DE_LOSS_CYC,
    parameter int unsigned LINK_LOSS = rxpo_pkg::LINK_LOSS_CYC,
    parameter int unsigned SYNC_ON   = rxpo_pkg::SYNC_ON_EDGES
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    // strap pins
    input  wire logic        pixels_per_clock_select,
    input  wire logic        output_clock_invert,
    input  wire logic        output_format_select,
    input  wire logic        drive_strength_select,
    input  wire logic        power_down_n,
    input  wire logic        output_disable_n,
    // recovered link
    input  wire logic        link_clk,
    input  wire logic [23:0] link_pixel,
    input  wire logic        link_de,
    input  wire logic        link_hsync,
    input  wire logic        link_vsync,
    input  wire logic [2:0]  link_ctl,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    // panel outputs, enable low while driving
    output logic      [35:0] pixel_out_bus,
    output logic             output_pixel_clock,
    output logic             data_enable_out,
    output logic             hsync_out,
    output logic             vsync_out,
    output logic             general_control_2,
    output logic             general_control_3,
    output logic             out_oe_b,
    // always driven outputs
    output logic             general_control_1,
    output logic             sync_detect,
    output logic             drive_strength_full
);
    import rxpo_pkg::*;

    // ==========================================================
    // input synchronisers
    logic [5:0]  strap_s1;
    logic [5:0]  strap_q;
    logic [30:0] lnk_s1;
    logic [30:0] lnk_q;
    logic        lclk_d;

    // two flops on every strap and link input
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_s1 <= '0;
            strap_q  <= '0;
            lnk_s1   <= '0;
            lnk_q    <= '0;
            lclk_d   <= 1'b0;
        end else begin
            strap_s1 <= {output_disable_n, power_down_n, drive_strength_select,
                         output_format_select, output_clock_invert, pixels_per_clock_select};
            strap_q  <= strap_s1;
            lnk_s1   <= {link_clk, link_ctl, link_vsync, link_hsync, link_de, link_pixel};
            lnk_q    <= lnk_s1;
            lclk_d   <= lnk_q[30];
        end
    end

    logic        dual;
    logic        inv;
    logic        fmt;
    logic        pwr_ok;
    logic        out_ok;
    logic [23:0] l_pix;
    logic        l_de;
    logic [2:0]  l_ctl;
    logic        pix_stb;

    // strap and link field decode
    assign dual    = strap_q[0];
    assign inv     = strap_q[1];
    assign fmt     = strap_q[2];
    assign pwr_ok  = strap_q[4];
    assign out_ok  = strap_q[5];
    assign l_pix   = lnk_q[23:0];
    assign l_de    = lnk_q[24];
    assign l_ctl   = lnk_q[29:27];
    assign pix_stb = lnk_q[30] & ~lclk_d & pwr_ok;

    // ==========================================================
    // pixel pairing
    function automatic logic [17:0] pix18(input logic [23:0] p);
        pix18 = {p[23:18], p[15:10], p[7:2]};
    endfunction

    logic        de_last_reg;
    logic        phase_reg;
    logic [17:0] even_reg;
    logic        de_rise;
    logic        slot_odd;
    logic        emit;

    assign de_rise  = pix_stb & l_de & ~de_last_reg;
    assign slot_odd = phase_reg & ~de_rise;
    assign emit     = pix_stb & (~dual | slot_odd);

    // even slot holds first pixel of a pair
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            de_last_reg <= 1'b0;
            phase_reg   <= 1'b0;
            even_reg    <= '0;
        end else if (!pwr_ok) begin
            de_last_reg <= 1'b0;
            phase_reg   <= 1'b0;
            even_reg    <= '0;
        end else if (pix_stb) begin
            de_last_reg <= l_de;
            phase_reg   <= dual & ~slot_odd;
            if (dual && !slot_odd) begin
                even_reg <= pix18(l_pix);
            end
        end
    end

    // ==========================================================
    // output data and controls
    logic [35:0] pix_reg;
    logic        de_reg;
    logic        hs_reg;
    logic        vs_reg;
    logic [2:0]  ctl_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pix_reg <= '0;
            de_reg  <= 1'b0;
            hs_reg  <= 1'b0;
            vs_reg  <= 1'b0;
            ctl_reg <= '0;
        end else if (!pwr_ok) begin
            pix_reg <= '0;
            de_reg  <= 1'b0;
            hs_reg  <= 1'b0;
            vs_reg  <= 1'b0;
            ctl_reg <= '0;
        end else if (emit) begin
            pix_reg <= dual ? {pix18(l_pix), even_reg} : {12'h000, l_pix};
            de_reg  <= l_de;
            hs_reg  <= lnk_q[25];
            vs_reg  <= lnk_q[26];
            ctl_reg <= l_ctl;
        end
    end

    // ==========================================================
    // output clock generator
    logic       clk_int_reg;
    logic [3:0] hi_cnt_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            clk_int_reg <= 1'b0;
            hi_cnt_reg  <= '0;
        end else if (!pwr_ok) begin
            clk_int_reg <= 1'b0;
            hi_cnt_reg  <= '0;
        end else if (emit) begin
            clk_int_reg <= 1'b1;
            hi_cnt_reg  <= 4'(CLK_HIGH_CYC - 1);
        end else if (hi_cnt_reg != 4'h0) begin
            hi_cnt_reg <= hi_cnt_reg - 4'h1;
        end else begin
            clk_int_reg <= 1'b0;
        end
    end

    assign output_pixel_clock = (fmt & ~de_reg) ? 1'b0 : (clk_int_reg ^ inv);

    // ==========================================================
    // output enables and drive
    logic oe_b_reg;
    logic drv_full_reg;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_b_reg     <= 1'b1;
            drv_full_reg <= 1'b0;
        end else begin
            oe_b_reg     <= ~(pwr_ok & out_ok);
            drv_full_reg <= strap_q[3];
        end
    end

    assign pixel_out_bus       = pix_reg;
    assign data_enable_out     = de_reg;
    assign hsync_out           = hs_reg;
    assign vsync_out           = vs_reg;
    assign general_control_1   = ctl_reg[0];
    assign general_control_2   = ctl_reg[1];
    assign general_control_3   = ctl_reg[2];
    assign out_oe_b            = oe_b_reg;
    assign drive_strength_full = drv_full_reg;

    // ==========================================================
    // sync detect
    logic [5:0]       edge_cnt_reg;
    logic [TMR_W-1:0] de_tmr_reg;
    logic [TMR_W-1:0] lnk_tmr_reg;
    logic             sync_reg;
    logic             de_lost;
    logic             lnk_lost;
    logic             de_fall;

    assign de_fall  = pix_stb & ~l_de & de_last_reg;
    assign de_lost  = de_tmr_reg == TMR_W'(DE_LOSS);
    assign lnk_lost = lnk_tmr_reg == TMR_W'(LINK_LOSS);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            de_tmr_reg  <= '0;
            lnk_tmr_reg <= '0;
        end else begin
            if (pix_stb && (l_de != de_last_reg)) begin
                de_tmr_reg <= '0;
            end else if (!de_lost) begin
                de_tmr_reg <= de_tmr_reg + 1'b1;
            end
            if (lnk_q[30] != lclk_d) begin
                lnk_tmr_reg <= '0;
            end else if (!lnk_lost) begin
                lnk_tmr_reg <= lnk_tmr_reg + 1'b1;
            end
        end
    end

    // count enable falls to raise detect
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            edge_cnt_reg <= '0;
        end else if (!pwr_ok || de_lost || lnk_lost) begin
            edge_cnt_reg <= '0;
        end else if (de_fall && edge_cnt_reg != 6'(SYNC_ON)) begin
            edge_cnt_reg <= edge_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_reg <= 1'b0;
        end else begin
            sync_reg <= pwr_ok & ~de_lost & ~lnk_lost & (edge_cnt_reg == 6'(SYNC_ON));
        end
    end

    assign sync_detect = sync_reg;

    // ==========================================================
    // output clock rate check
    logic [7:0] per_cnt_reg;
    logic       seen_reg;
    logic       rate_err;
    logic [7:0] per_min;
    logic [7:0] per_max;

    assign per_min  = dual ? 8'(DUAL_MIN_CYC) : 8'(SINGLE_MIN_CYC);
    assign per_max  = dual ? 8'(DUAL_MAX_CYC) : 8'(SINGLE_MAX_CYC);
    assign rate_err = emit & seen_reg & ((per_cnt_reg < per_min) | (per_cnt_reg > per_max));

    // period counter between output clocks
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            per_cnt_reg <= '0;
            seen_reg    <= 1'b0;
        end else if (!pwr_ok || lnk_lost) begin
            per_cnt_reg <= '0;
            seen_reg    <= 1'b0;
        end else if (emit) begin
            per_cnt_reg <= 8'h01;
            seen_reg    <= 1'b1;
        end else if (per_cnt_reg != 8'hff) begin
            per_cnt_reg <= per_cnt_reg + 8'h01;
        end
    end

    // ==========================================================
    // registers and interrupt
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_mask_reg;
    logic [2:0]  irq_ev;
    logic [2:0]  irq_clr;
    logic        sync_d;
    logic [31:0] rdata_reg;

    assign irq_ev  = {rate_err, sync_d & ~sync_reg, sync_reg & ~sync_d};
    assign irq_clr = (reg_wr && reg_addr == REG_IRQ_STATUS) ? reg_wdata[2:0] : 3'h0;

    // sticky events, set wins over clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_d       <= 1'b0;
            irq_stat_reg <= '0;
            irq_mask_reg <= IRQ_MASK_RST;
        end else begin
            sync_d       <= sync_reg;
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
            if (reg_wr && reg_addr == REG_IRQ_MASK) begin
                irq_mask_reg <= reg_wdata[2:0];
            end
        end
    end

    // read data valid one cycle after strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                REG_STATUS:     rdata_reg <= {28'h000_0000, oe_b_reg, ~pwr_ok, dual, sync_reg};
                REG_IRQ_STATUS: rdata_reg <= {29'h0000_0000, irq_stat_reg};
                REG_IRQ_MASK:   rdata_reg <= {29'h0000_0000, irq_mask_reg};
                default:        rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq       = |(irq_stat_reg & irq_mask_reg);

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_single_upper_low: assert property (emit && !dual |=>
        pix_reg[35:24] == 12'h000 && pix_reg[23:0] == $past(l_pix))
        else $error("single mode lanes wrong");
    a_dual_pair_split: assert property (emit && dual |=>
        pix_reg[17:0] == $past(even_reg) && pix_reg[35:18] == $past(pix18(l_pix)))
        else $error("dual mode lanes wrong");
    a_data_with_clk: assert property ($changed(pix_reg) && pwr_ok |->
        $rose(clk_int_reg))
        else $error("data changed off clock edge");
    a_off_tristate: assert property (!(pwr_ok && out_ok) |=> out_oe_b)
        else $error("outputs driven while off");
    a_general_control_1_stays: assert property (!out_ok && pwr_ok && emit |=>
        general_control_1 == $past(l_ctl[0]))
        else $error("control 1 not updated");
    a_sleep_clears: assert property (!pwr_ok |=> !sync_detect && !clk_int_reg)
        else $error("power-down left logic active");
    a_clk_edge_sel: assert property ($rose(clk_int_reg) && !fmt |->
        output_pixel_clock == !inv)
        else $error("clock polarity wrong");
    a_clk_gated: assert property (fmt && !de_reg |-> !output_pixel_clock)
        else $error("gated clock not low");
    // power-down may cut a high phase short
    a_clk_high_time: assert property ($rose(clk_int_reg) |-> (clk_int_reg || !pwr_ok)[*4])
        else $error("clock high time short");
    a_sync_rise: assert property ($rose(sync_reg) |->
        $past(edge_cnt_reg) == 6'(SYNC_ON) && SYNC_ON <= SYNC_MAX_EDGES)
        else $error("sync detect rose early");
    a_sync_fall: assert property (de_lost || lnk_lost |=> !sync_reg)
        else $error("sync detect not dropped");
    a_pair_restart: assert property (de_rise && dual |=> phase_reg)
        else $error("pairing not restarted");
    a_rate_flag: assert property (rate_err |=> irq_stat_reg[IRQ_RATE])
        else $error("rate error not flagged");

    c_sync_up: cover property ($rose(sync_reg));
    c_dual_emit: cover property (emit && dual ##1 emit && dual);
    c_gated_stop: cover property (fmt && $fell(de_reg));
    c_power_down: cover property (sync_reg ##1 !pwr_ok);
endmodule
`default_nettype wire
